/* File: rtl/spi_cfg_pkg.sv */
`default_nettype none
package spi_cfg_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int         ADDR_W     = 15;
   localparam int         INSTR_W    = 16;
   localparam int         BYTE_W     = 8;
   localparam int         RW_BIT     = 15;
   localparam logic [4:0] INSTR_LAST = 5'h0f;
   localparam logic [4:0] BYTE_LAST  = 5'h07;
   localparam logic [4:0] CNT_ZERO   = 5'h00;
   localparam logic [4:0] CNT_STEP   = 5'h01;
   localparam logic [14:0] ADDR_STEP = 15'h0001;

   // ----------------------------------------------------------------
   // Port configuration register
   // ----------------------------------------------------------------
   localparam logic [14:0] ADDR_CONFIG_A  = 15'h0000;
   localparam logic [7:0]  CONFIG_A_RESET = 8'h00;
   // Soft reset bit and its mirror are self clearing
   localparam logic [7:0]  SOFT_RESET_MASK = 8'h81;

   // Index into the effective control nibble
   localparam int CTL_SOFT_RESET  = 3;
   localparam int CTL_LSB_FIRST   = 2;
   localparam int CTL_ADDR_ASCEND = 1;
   localparam int CTL_SERIAL_OUT  = 0;

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   localparam int         PIN_W       = 5;
   localparam int         PIN_CS_N    = 0;
   localparam int         PIN_SCLK    = 1;
   localparam int         PIN_SDIO    = 2;
   localparam int         PIN_I2C     = 3;
   localparam int         PIN_PROFILE = 4;
   localparam logic [4:0] PIN_RESET   = 5'h01;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_INSTR,
      ST_DATA
   } port_state_t;

   function automatic logic [7:0] reverse8(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < BYTE_W; i++) begin
         r[i] = v[BYTE_W-1-i];
      end
      return r;
   endfunction

   // Each control is the OR of its bit and its mirror
   function automatic logic [3:0] mirror_or(input logic [7:0] v);
      return v[7:4] | {v[0], v[1], v[2], v[3]};
   endfunction

endpackage
`default_nettype wire

/* File: rtl/pin_sync_if.sv */
`default_nettype none
interface pin_sync_if;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_active;
   logic sdio;
   logic i2c_mode;
   logic profile_en;

   modport source (
      output sclk_rise,
      output sclk_fall,
      output cs_active,
      output sdio,
      output i2c_mode,
      output profile_en
   );

   modport sink (
      input sclk_rise,
      input sclk_fall,
      input cs_active,
      input sdio,
      input i2c_mode,
      input profile_en
   );
endinterface
`default_nettype wire

/* File: rtl/pin_sync.sv */
`default_nettype none
module pin_sync
   import spi_cfg_pkg::*;
(
   input  wire logic             i_clock,
   input  wire logic             i_sys_rst,
   input  wire logic [PIN_W-1:0] i_pins,
   pin_sync_if.source            bus
);

   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
   } sync_state_t;

   sync_state_t r;
   sync_state_t next_r;

   always_comb begin
      next_r    = r;
      next_r.s1 = i_pins;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r <= {PIN_RESET, PIN_RESET, PIN_RESET};
      end else begin
         r <= next_r;
      end
   end

   // Edges are taken between stages two and three only
   assign bus.sclk_rise  = r.s2[PIN_SCLK] & ~r.s3[PIN_SCLK];
   assign bus.sclk_fall  = ~r.s2[PIN_SCLK] & r.s3[PIN_SCLK];
   assign bus.cs_active  = ~r.s2[PIN_CS_N];
   assign bus.sdio       = r.s2[PIN_SDIO];
   assign bus.i2c_mode   = r.s2[PIN_I2C];
   assign bus.profile_en = r.s2[PIN_PROFILE];

endmodule
`default_nettype wire

/* File: rtl/serial_port_config_control.sv */
`default_nettype none
module serial_port_config_control
   import spi_cfg_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   input  wire logic              i_spi_cs_n,
   input  wire logic              i_spi_sclk,
   input  wire logic              i_sdio,
   input  wire logic              i_i2c_mode,
   input  wire logic              i_profile_mem_en,
   input  wire logic [7:0]        i_reg_rdata,
   output var  logic              o_sdio,
   output var  logic              o_sdio_oe,
   output var  logic              o_serial_out,
   output var  logic              o_serial_out_oe,
   output var  logic [ADDR_W-1:0] o_reg_addr,
   output var  logic              o_reg_wr,
   output var  logic [7:0]        o_reg_wdata,
   output var  logic              o_soft_reset,
   output var  logic              o_profile_load
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   pin_sync_if pins ();

   pin_sync u_pin_sync (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_pins    ({i_profile_mem_en, i_i2c_mode, i_sdio, i_spi_sclk,
                   i_spi_cs_n}),
      .bus       (pins.source)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      port_state_t         state;
      logic [4:0]          bit_cnt;
      logic [INSTR_W-1:0]  shin;
      logic [7:0]          shout;
      logic                rd;
      logic                load_pending;
      logic                step_pending;
      logic [ADDR_W-1:0]   addr;
      logic [7:0]          cfg;
      logic                lsb_first;
      logic                addr_ascend;
      logic                serial_out_pin_enable;
      logic                sdio_oe;
      logic                serial_out_oe;
      logic                reg_wr;
      logic [7:0]          reg_wdata;
      logic                soft_reset;
      logic                profile_load;
   } port_regs_t;

   localparam port_regs_t REGS_RESET = '{
      state:                 ST_IDLE,
      bit_cnt:               CNT_ZERO,
      shin:                  16'h0000,
      shout:                 8'h00,
      rd:                    1'b0,
      load_pending:          1'b0,
      step_pending:          1'b0,
      addr:                  ADDR_CONFIG_A,
      cfg:                   CONFIG_A_RESET,
      lsb_first:             1'b0,
      addr_ascend:           1'b0,
      serial_out_pin_enable: 1'b0,
      sdio_oe:               1'b0,
      serial_out_oe:         1'b0,
      reg_wr:                1'b0,
      reg_wdata:             8'h00,
      soft_reset:            1'b0,
      profile_load:          1'b0
   };

   port_regs_t r;
   port_regs_t next_r;

   function automatic logic [ADDR_W-1:0] step_addr(
      input logic [ADDR_W-1:0] a,
      input logic              up
   );
      return up ? a + ADDR_STEP : a - ADDR_STEP;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [3:0]         ctl;
      logic [3:0]         wr_ctl;
      logic [INSTR_W-1:0] instr;
      logic [7:0]         data_byte;
      logic [7:0]         rdata;
      ctl       = mirror_or(r.cfg);
      wr_ctl    = 4'h0;
      instr     = 16'h0000;
      data_byte = 8'h00;
      rdata     = (r.addr == ADDR_CONFIG_A) ? r.cfg : i_reg_rdata;
      next_r    = r;
      next_r.reg_wr       = 1'b0;
      next_r.soft_reset   = 1'b0;
      next_r.profile_load = 1'b0;

      case (r.state)
         ST_IDLE: begin
            // Controls are frozen per frame so a config write never
            // changes bit order halfway through its own frame
            if (pins.cs_active && !pins.i2c_mode) begin
               next_r.state                 = ST_INSTR;
               next_r.bit_cnt               = CNT_ZERO;
               next_r.lsb_first             = ctl[CTL_LSB_FIRST];
               next_r.addr_ascend           = ctl[CTL_ADDR_ASCEND];
               next_r.serial_out_pin_enable = ctl[CTL_SERIAL_OUT];
            end
         end
         ST_INSTR: begin
            if (pins.sclk_rise) begin
               next_r.shin    = {r.shin[INSTR_W-2:0], pins.sdio};
               next_r.bit_cnt = r.bit_cnt + CNT_STEP;
               if (r.bit_cnt == INSTR_LAST) begin
                  instr = r.lsb_first
                        ? {reverse8(next_r.shin[7:0]),
                           reverse8(next_r.shin[15:8])}
                        : next_r.shin;
                  next_r.rd           = instr[RW_BIT];
                  next_r.addr         = instr[ADDR_W-1:0];
                  next_r.load_pending = instr[RW_BIT];
                  next_r.step_pending = 1'b0;
                  next_r.bit_cnt      = CNT_ZERO;
                  next_r.state        = ST_DATA;
               end
            end
         end
         ST_DATA: begin
            if (pins.sclk_fall) begin
               if (r.load_pending) begin
                  next_r.shout = r.lsb_first ? reverse8(rdata) : rdata;
                  next_r.load_pending = 1'b0;
               end else begin
                  next_r.shout = {r.shout[6:0], 1'b0};
               end
               if (r.step_pending) begin
                  next_r.addr = step_addr(r.addr, r.addr_ascend);
                  next_r.step_pending = 1'b0;
               end
            end
            if (pins.sclk_rise) begin
               next_r.shin    = {r.shin[INSTR_W-2:0], pins.sdio};
               next_r.bit_cnt = r.bit_cnt + CNT_STEP;
               if (r.bit_cnt == BYTE_LAST) begin
                  next_r.bit_cnt = CNT_ZERO;
                  data_byte = r.lsb_first ? reverse8(next_r.shin[7:0])
                                          : next_r.shin[7:0];
                  if (r.rd) begin
                     // Read steps now so the next byte can be fetched
                     next_r.addr = step_addr(r.addr, r.addr_ascend);
                     next_r.load_pending = 1'b1;
                  end else begin
                     next_r.step_pending = 1'b1;
                     if (r.addr == ADDR_CONFIG_A) begin
                        // Only the serial port writes this register;
                        // profile downloads have no path into it
                        wr_ctl = mirror_or(data_byte);
                        if (wr_ctl[CTL_SOFT_RESET]) begin
                           next_r.soft_reset   = 1'b1;
                           next_r.profile_load = pins.profile_en;
                           next_r.cfg          = CONFIG_A_RESET;
                        end else begin
                           next_r.cfg = data_byte & ~SOFT_RESET_MASK;
                        end
                     end else begin
                        next_r.reg_wr    = 1'b1;
                        next_r.reg_wdata = data_byte;
                     end
                  end
               end
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase

      // Frame ends on chip select release; I2C mode owns the pins
      if (!pins.cs_active || pins.i2c_mode) begin
         next_r.state        = ST_IDLE;
         next_r.load_pending = 1'b0;
         next_r.step_pending = 1'b0;
      end

      // 3-wire turns the shared data pin around; 4-wire uses its own
      next_r.sdio_oe = (next_r.state == ST_DATA) && next_r.rd
                     && !next_r.serial_out_pin_enable;
      next_r.serial_out_oe = (next_r.state == ST_DATA) && next_r.rd
                           && next_r.serial_out_pin_enable;
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r <= REGS_RESET;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_sdio          = r.shout[7];
   assign o_sdio_oe       = r.sdio_oe;
   assign o_serial_out    = r.shout[7];
   assign o_serial_out_oe = r.serial_out_oe;
   assign o_reg_addr      = r.addr;
   assign o_reg_wr        = r.reg_wr;
   assign o_reg_wdata     = r.reg_wdata;
   assign o_soft_reset    = r.soft_reset;
   assign o_profile_load  = r.profile_load;

endmodule
`default_nettype wire

/* File: testbench/spi_cfg_sva.sv */
`default_nettype none
module spi_cfg_sva
   import spi_cfg_pkg::*;
(
   input wire logic              i_clock,
   input wire logic              i_sys_rst,
   input wire logic              i_spi_cs_n,
   input wire logic              i_i2c_mode,
   input wire logic              i_profile_mem_en,
   input wire logic              o_sdio_oe,
   input wire logic              o_serial_out_oe,
   input wire logic [ADDR_W-1:0] o_reg_addr,
   input wire logic              o_reg_wr,
   input wire logic              o_soft_reset,
   input wire logic              o_profile_load
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   a_load_needs_reset: assert property (o_profile_load |-> o_soft_reset)
      else $error("profile load without soft reset");
   a_reset_single: assert property (o_soft_reset |=> !o_soft_reset [*8])
      else $error("soft reset longer than one cycle");
   a_load_follows_en: assert property (o_soft_reset &&
      $past(i_profile_mem_en, 5) == i_profile_mem_en
      |-> o_profile_load == i_profile_mem_en)
      else $error("profile load does not follow enable");
   a_cfg_not_mapped: assert property (
      o_reg_wr |-> o_reg_addr != ADDR_CONFIG_A)
      else $error("write strobe for the config address");
   a_wr_spaced: assert property (o_reg_wr |=> !o_reg_wr [*8])
      else $error("write strobes closer than a byte");
   a_oe_exclusive: assert property (!(o_sdio_oe && o_serial_out_oe))
      else $error("both data outputs enabled");
   a_oe_idle: assert property (i_spi_cs_n && $past(i_spi_cs_n, 6)
      |-> !o_sdio_oe && !o_serial_out_oe)
      else $error("output enabled outside a frame");
   a_i2c_silent: assert property (i_i2c_mode && $past(i_i2c_mode, 6)
      |-> !(o_sdio_oe || o_serial_out_oe || o_reg_wr || o_soft_reset))
      else $error("serial activity in i2c mode");
endmodule
bind serial_port_config_control spi_cfg_sva chk (.i_clock, .i_sys_rst,
   .i_spi_cs_n, .i_i2c_mode, .i_profile_mem_en, .o_sdio_oe, .o_serial_out_oe,
   .o_reg_addr, .o_reg_wr, .o_soft_reset, .o_profile_load);
`default_nettype wire

/* File: testbench/spi_host_model.sv */
`default_nettype none
module spi_host_model (
   input  wire logic i_clock,
   input  wire logic i_miso,
   output var  logic o_cs_n,
   output var  logic o_sclk,
   output var  logic o_mosi,
   output var  logic o_mosi_en
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
      o_mosi_en = 1'b0;
   end
   // -----------------------------------------
   // Mode 0 frame, SCLK still between frames
   // -----------------------------------------
   // Read data is taken late in the high phase, as output lags the pin fall
   task automatic xfer(input logic [31:0] tx, input int nout,
                       output logic [31:0] rx);
      rx = 32'h0;
      @(posedge i_clock) o_cs_n <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         repeat (4) @(posedge i_clock);
         o_mosi_en <= (i < nout);
         o_mosi <= tx[31-i];
         repeat (4) @(posedge i_clock);
         o_sclk <= 1'b1;
         repeat (4) @(posedge i_clock);
         rx = {rx[30:0], i_miso};
         o_sclk <= 1'b0;
      end
      repeat (4) @(posedge i_clock);
      o_cs_n <= 1'b1;
      o_mosi_en <= 1'b0;
      repeat (8) @(posedge i_clock);
   endtask
endmodule
`default_nettype wire

/* File: testbench/serial_port_config_control_tb.sv */
`default_nettype none
module serial_port_config_control_tb;
   import spi_cfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, sys_rst, i2c, prof_en, tgl, lsb, up, four;
   logic        cs_n, sclk, mosi, mosi_en, sdio_w, miso, wr, srst, pload;
   logic        dsdio, dsdio_oe, sout, sout_oe;
   logic [7:0]  rdata, wdata, cfg;
   logic [14:0] addr;
   logic [22:0] wq[$];
   logic [7:0]  pat[10] = '{8'h18, 8'h24, 8'h42, 8'h81, 8'h08,
                            8'h04, 8'h02, 8'h7e, 8'h01, 8'h00};
   int          miscompares, comparisons, nsr, npl, esr, epl, cycles, seed;

   always #25 clock = ~clock;
   // Undriven line keeps toggling so a stale value cannot pass
   assign sdio_w = dsdio_oe ? dsdio : mosi_en ? mosi : tgl;
   assign miso   = four ? (sout_oe ? sout : tgl) : sdio_w;

   serial_port_config_control dut (.i_clock(clock), .i_sys_rst(sys_rst),
      .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_sdio(sdio_w),
      .i_i2c_mode(i2c), .i_profile_mem_en(prof_en), .i_reg_rdata(rdata),
      .o_sdio(dsdio), .o_sdio_oe(dsdio_oe), .o_serial_out(sout),
      .o_serial_out_oe(sout_oe), .o_reg_addr(addr), .o_reg_wr(wr),
      .o_reg_wdata(wdata), .o_soft_reset(srst), .o_profile_load(pload));
   spi_host_model host (.i_clock(clock), .i_miso(miso), .o_cs_n(cs_n),
      .o_sclk(sclk), .o_mosi(mosi), .o_mosi_en(mosi_en));

   function automatic logic [7:0] rmap(input logic [14:0] a);
      return a[7:0] ^ a[14:7] ^ 8'h5a;
   endfunction

   always @(posedge clock) begin
      tgl <= ~tgl;
      rdata <= rmap(addr);
      if (wr) wq.push_back({addr, wdata});
      nsr += srst;
      npl += pload;
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         miscompares++;
      end
   endtask

   task automatic final_report();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // -----------------------------------------
   // One two-byte frame, checked against a model
   // -----------------------------------------
   task automatic xact(input logic rdn, input logic [14:0] a,
                       input logic [15:0] d);
      logic [15:0] hw, exp;
      logic [7:0]  b0, b1, bt;
      logic [31:0] rx;
      logic [14:0] ak;
      logic [3:0]  e;
      hw = {rdn, a};
      b0 = d[15:8];
      b1 = d[7:0];
      exp = 16'h0;
      if (lsb) begin
         hw = {<<{hw}};
         b0 = {<<{b0}};
         b1 = {<<{b1}};
      end
      host.xfer({hw, b0, b1}, rdn ? 16 : 32, rx);
      b0 = rx[15:8];
      b1 = rx[7:0];
      if (lsb) begin
         b0 = {<<{b0}};
         b1 = {<<{b1}};
      end
      for (int k = 0; k < 2 && !i2c; k++) begin
         ak = up ? a + 15'(k) : a - 15'(k);
         bt = (k == 0) ? d[15:8] : d[7:0];
         if (rdn) exp = {exp[7:0], (ak == 15'h0) ? cfg : rmap(ak)};
         else if (ak != 15'h0) check(wq.pop_front(), {ak, bt});
         else if (bt[7] | bt[0]) begin
            cfg = 8'h00;
            esr++;
            epl += prof_en;
         end else cfg = bt;
      end
      if (rdn && !i2c) check({b0, b1}, exp);
      check(wq.size(), 0);
      check(nsr, esr);
      check(npl, epl);
      e = cfg[7:4] | {cfg[0], cfg[1], cfg[2], cfg[3]};
      {lsb, up, four} = e[2:0];
   endtask

   initial begin
      seed = 32'h3766;
      clock = 0;
      tgl = 0;
      sys_rst = 1;
      i2c = 0;
      prof_en = 0;
      rdata = 8'h00;
      cfg = 8'h00;
      {lsb, up, four} = 3'h0;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      xact(1'b1, 15'h0001, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         prof_en <= 1'($random(seed));
         xact(1'b0, up ? 15'h7fff : 15'h0001,
              {8'($random(seed)), pat[i]});
         xact(1'b1, 15'($random(seed)), 16'h0000);
         xact(1'b0, 15'($random(seed)) | 15'h0002,
              16'($random(seed)));
      end
      i2c <= 1'b1;
      repeat (8) @(posedge clock);
      xact(1'b0, 15'h0001, 16'h1818);
      xact(1'b1, 15'h0001, 16'h0000);
      i2c <= 1'b0;
      repeat (8) @(posedge clock);
      xact(1'b1, 15'h0001, 16'h0000);
      final_report();
   end
endmodule
`default_nettype wire
